/* ifd_pkg.sv */
// Package for the instruction format and timing decoder.
// Assumes a single system clock; no software-visible registers.
package ifd_pkg;

	localparam int IFD_WORD_W      = 16;
	localparam int IFD_OPC_W       = 8;
	localparam int IFD_TBL_PTR_W   = 21;
	localparam int IFD_OSC_PER_CYC = 4;
	localparam int IFD_STD_COUNT   = 75;
	localparam int IFD_EXT_COUNT   = 8;
	// Upper nibble that marks the second word of a double-word instruction.
	localparam logic [3:0] IFD_SECOND_MARK = 4'hF;
	// Field positions inside a single instruction word.
	localparam int IFD_POS_FILE  = 0;
	localparam int IFD_POS_ACC   = 8;
	localparam int IFD_POS_DEST  = 9;
	localparam int IFD_POS_BIT   = 9;
	localparam int IFD_POS_FAST  = 0;
	localparam int IFD_POS_TMODE = 0;
	localparam int IFD_POS_PTR   = 4;
	localparam int IFD_POS_TOP   = 12;
	// Reset values.
	localparam logic [1:0] IFD_PHASE_RST = 2'h0;

	typedef enum logic [1:0]
	{
		IFD_CLS_BYTE    = 2'b00,
		IFD_CLS_BIT     = 2'b01,
		IFD_CLS_LITERAL = 2'b10,
		IFD_CLS_CONTROL = 2'b11
	} ifd_class_t;

	typedef enum logic [1:0]
	{
		IFD_TM_NONE     = 2'b00,
		IFD_TM_POST_INC = 2'b01,
		IFD_TM_POST_DEC = 2'b10,
		IFD_TM_PRE_INC  = 2'b11
	} ifd_tmode_t;

	typedef enum logic [1:0]
	{
		IFD_ST_FIRST  = 2'b00,
		IFD_ST_SECOND = 2'b01,
		IFD_ST_FLUSH  = 2'b10,
		IFD_ST_FLUSH2 = 2'b11
	} ifd_state_t;

	// Operation properties supplied by the external encoding table.
	typedef struct packed
	{
		logic       valid;
		ifd_class_t op_class;
		logic       double_word;
		logic       conditional;
		logic       changes_pc;
		logic       uses_file_ptr;
		logic       uses_fast;
		logic       uses_tmode;
		logic       has_literal;
		logic       names_pointer;
		logic [6:0] op_index;
	} ifd_table_t;

	// Decoded instruction presented to the register file and program counter.
	typedef struct packed
	{
		logic       valid;
		logic       is_nop;
		ifd_class_t op_class;
		logic [6:0] op_index;
		logic [7:0] file_addr;
		logic [1:0] ptr_sel;
		logic       use_ptr;
		logic       bank_select;
		logic       to_file;
		logic       to_working;
		logic [2:0] bit_num;
		logic [7:0] bit_mask;
		logic [7:0] literal;
		logic       write_pointer;
		logic       fast_save;
		ifd_tmode_t tbl_mode;
		logic [IFD_WORD_W-1:0] second_word;
		logic       two_word;
	} ifd_decoded_t;

	typedef struct packed
	{
		ifd_state_t   state;
		logic [1:0]   phase;
		logic [IFD_WORD_W-1:0] first_word;
		ifd_table_t   first_info;
		logic         want_taken;
		ifd_decoded_t dec;
		logic         cycle_strobe;
		logic         fetch_next;
		logic         busy;
	} ifd_state_s_t;

endpackage : ifd_pkg

/* ifd_decoder.sv */
// Instruction format classifier and execution timing sequencer.
// Assumes the fetch path holds fetch_word stable for one instruction
// cycle and the encoding table answers combinationally.
`timescale 1ns/100ps

// Notes on behaviour
// [RULE_01] Serve 75 standard and 8 extended operations via table indices.
// [RULE_02] A single-word instruction is one 16-bit word: opcode, operands.
// [RULE_03] Every instruction is in one class: byte, bit, literal, control.
// [RULE_04] Byte ops: destination clear goes to working register, set to file.
// [RULE_05] Bit ops: a bit-number field picks the one bit touched or tested.
// [RULE_06] Literal ops carry a constant, may name a pointer, or none.
// [RULE_07] Control ops take address, fast selector, table mode, or nothing.
// [RULE_08] Four instructions span two words; second word top nibble is ones.
// [RULE_09] A lone second word executes as a no-operation.
// [RULE_10] Single-word ops take one cycle, two when taken or PC changes.
// [RULE_11] Two-word instructions take two instruction cycles.
// [RULE_12] One instruction cycle is four oscillator periods.
// [RULE_13] A taken two-word branch takes three instruction cycles.
// [RULE_14] Access selector clear uses access bank, set uses bank select.
// [RULE_15] File field is 8 bits, or a 2-bit pointer designator.
// [RULE_16] Fast selector set saves or restores shadows; clear leaves them.
// [RULE_17] Table modes: no change, post-inc, post-dec, pre-inc of pointer.
// [RULE_18] Exact opcode patterns come from a separate encoding table.
module ifd_decoder
	import ifd_pkg::*;
#(
	parameter int OSC_PER_CYC = IFD_OSC_PER_CYC
)
(
	input  wire logic                  clk_sys,
	input  wire logic                  sys_rst,
	input  wire logic [IFD_WORD_W-1:0] fetch_word,
	input  wire logic                  fetch_valid,
	input  wire ifd_table_t            table_info,
	input  wire logic                  cond_taken,
	output logic [IFD_OPC_W-1:0]       table_opcode,
	output ifd_decoded_t               decoded,
	output logic                       cycle_strobe,
	output logic                       fetch_next,
	output logic                       busy
);

	// [RULE_12] Four-phase cycle
	if (OSC_PER_CYC != 4)
	begin : g_bad_osc
		$error("ifd_decoder: OSC_PER_CYC must be 4");
	end

	// [RULE_01] Index room check
	// The operation index is seven bits wide.
	if (IFD_STD_COUNT + IFD_EXT_COUNT > 2 ** 7)
	begin : g_bad_count
		$error("ifd_decoder: operation index too narrow");
	end

	ifd_state_s_t st;
	ifd_state_s_t next_st;

	// [RULE_02] Opcode portion split
	// [RULE_18] Table lookup key
	assign table_opcode = fetch_word[IFD_WORD_W-1 -: IFD_OPC_W];

	function automatic ifd_decoded_t build(
		input logic [IFD_WORD_W-1:0] w,
		input ifd_table_t            t
	);
		ifd_decoded_t d;
		d = '0;
		d.valid       = t.valid;
		d.op_class    = t.op_class;
		d.op_index    = t.op_index;
		d.two_word    = t.double_word;
		// [RULE_15] File or pointer
		d.file_addr   = w[IFD_POS_FILE +: 8];
		d.use_ptr     = t.uses_file_ptr;
		d.ptr_sel     = t.names_pointer ? w[IFD_POS_PTR +: 2]
		                                : w[IFD_POS_FILE +: 2];
		// [RULE_14] Bank selection
		d.bank_select = w[IFD_POS_ACC];
		case (t.op_class)
			IFD_CLS_BYTE:
			begin
				// [RULE_04] Destination steering
				d.to_file    = w[IFD_POS_DEST];
				d.to_working = ~w[IFD_POS_DEST];
			end
			IFD_CLS_BIT:
			begin
				// [RULE_05] Bit selection
				d.bit_num  = w[IFD_POS_BIT +: 3];
				d.bit_mask = 8'h01 << w[IFD_POS_BIT +: 3];
			end
			IFD_CLS_LITERAL:
			begin
				// [RULE_06] Literal operand
				d.bank_select   = 1'b0;
				d.literal       = t.has_literal ? w[7:0] : 8'h00;
				d.write_pointer = t.names_pointer;
			end
			IFD_CLS_CONTROL:
			begin
				// [RULE_07] Control operands
				d.bank_select = 1'b0;
				d.literal     = w[7:0];
				// [RULE_16] Fast shadow mode
				d.fast_save   = t.uses_fast & w[IFD_POS_FAST];
				// [RULE_17] Table pointer mode
				d.tbl_mode    = t.uses_tmode ?
					ifd_tmode_t'(w[IFD_POS_TMODE +: 2]) : IFD_TM_NONE;
			end
			default:
			begin
				d.valid = 1'b0;
			end
		endcase
		return d;
	endfunction : build

	always_comb
	begin
		next_st = st;
		next_st.cycle_strobe = 1'b0;
		next_st.fetch_next   = 1'b0;
		// [RULE_12] Phase counter
		next_st.phase = st.phase + 2'h1;
		if (st.phase == 2'(OSC_PER_CYC - 1))
		begin
			next_st.cycle_strobe = 1'b1;
			case (st.state)
				IFD_ST_FIRST:
				begin
					if (fetch_valid)
					begin
						next_st.fetch_next = 1'b1;
						// [RULE_09] Orphan second word
						if (fetch_word[IFD_POS_TOP +: 4] == IFD_SECOND_MARK
							&& !table_info.valid)
						begin
							next_st.dec        = '0;
							next_st.dec.valid  = 1'b1;
							next_st.dec.is_nop = 1'b1;
							next_st.busy       = 1'b0;
						end
						// [RULE_08] Double-word start
						else if (table_info.double_word)
						begin
							next_st.first_word = fetch_word;
							next_st.first_info = table_info;
							next_st.dec        = '0;
							next_st.busy       = 1'b1;
							next_st.state      = IFD_ST_SECOND;
						end
						else
						begin
							// [RULE_03] Single class decode
							next_st.dec = build(fetch_word, table_info);
							// [RULE_10] Extra cycle when taken
							if ((table_info.conditional && cond_taken)
								|| table_info.changes_pc)
							begin
								next_st.busy  = 1'b1;
								next_st.state = IFD_ST_FLUSH2;
							end
							else
								next_st.busy = 1'b0;
						end
					end
					else
						next_st.dec = '0;
				end
				IFD_ST_SECOND:
				begin
					// [RULE_11] Second cycle of two
					if (fetch_valid)
					begin
						next_st.fetch_next = 1'b1;
						next_st.dec = build(st.first_word, st.first_info);
						next_st.dec.second_word = fetch_word;
						// [RULE_13] Taken branch third cycle
						if ((st.first_info.conditional && cond_taken)
							|| st.first_info.changes_pc)
						begin
							next_st.state = IFD_ST_FLUSH2;
						end
						else
						begin
							next_st.busy  = 1'b0;
							next_st.state = IFD_ST_FIRST;
						end
					end
				end
				IFD_ST_FLUSH2, IFD_ST_FLUSH:
				begin
					next_st.dec        = '0;
					next_st.dec.valid  = 1'b1;
					next_st.dec.is_nop = 1'b1;
					next_st.busy       = 1'b0;
					next_st.state      = IFD_ST_FIRST;
				end
				default:
				begin
					next_st.state = IFD_ST_FIRST;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st       <= '0;
			st.phase <= IFD_PHASE_RST;
			st.state <= IFD_ST_FIRST;
		end
		else
			st <= next_st;
	end

	assign decoded      = st.dec;
	assign cycle_strobe = st.cycle_strobe;
	assign fetch_next   = st.fetch_next;
	assign busy         = st.busy;

endmodule : ifd_decoder

/* ifd_table_model.sv */
// Encoding table model for the decoder bench.
// Assumes the decoder indexes it with table_opcode, no clock.
`timescale 1ns/100ps
module ifd_table_model
	import ifd_pkg::*;
(
	input  wire logic [IFD_OPC_W-1:0] table_opcode,
	output ifd_table_t                table_info
);
	logic [3:0] grp;
	assign grp = table_opcode[7:4];
	always_comb
	begin
		table_info = '0;
		table_info.valid = (grp != 4'hF);
		table_info.op_index = table_opcode[6:0];
		table_info.op_class = (grp < 4'h4) ? IFD_CLS_BYTE :
			(grp < 4'h8) ? IFD_CLS_BIT :
			(grp < 4'hA) ? IFD_CLS_LITERAL : IFD_CLS_CONTROL;
		table_info.uses_file_ptr = (grp < 4'h8);
		table_info.has_literal = (grp == 4'h8) || (grp == 4'h9);
		table_info.names_pointer = (grp == 4'h9);
		table_info.uses_fast = (grp == 4'hA);
		table_info.changes_pc = (grp == 4'hA);
		table_info.uses_tmode = (grp == 4'hB);
		table_info.double_word = (grp == 4'hC) || (grp == 4'hE);
		table_info.conditional = (grp == 4'hD) || (grp == 4'hE);
	end
endmodule : ifd_table_model

/* ifd_monitor.sv */
// Port assertions for the instruction decoder.
// Assumes it is bound to the decoder top module.
`timescale 1ns/100ps
module ifd_monitor
	import ifd_pkg::*;
(
	input wire logic                  clk_sys,
	input wire logic                  sys_rst,
	input wire logic [IFD_WORD_W-1:0] fetch_word,
	input wire logic                  fetch_valid,
	input wire ifd_table_t            table_info,
	input wire logic                  cond_taken,
	input wire ifd_decoded_t          decoded,
	input wire logic                  cycle_strobe,
	input wire logic                  fetch_next
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence quiet_3;
		!cycle_strobe [*3];
	endsequence
	sequence took_single;
		fetch_next && decoded.valid && !decoded.two_word && !decoded.is_nop;
	endsequence
	AST_CYCLE_LEN: assert property (
		cycle_strobe |=> quiet_3 ##1 cycle_strobe) else $error("bad spacing");
	AST_HOLD: assert property (
		cycle_strobe |=> $stable(decoded) [*3]) else $error("decode moved");
	AST_FETCH: assert property (
		fetch_next |-> cycle_strobe && $past(fetch_valid))
		else $error("bad fetch");
	AST_DEST: assert property (
		took_single ##0 decoded.op_class == IFD_CLS_BYTE
		|-> decoded.to_file == $past(fetch_word[9])) else $error("bad dest");
	AST_ACCESS: assert property (
		took_single ##0 decoded.op_class == IFD_CLS_BYTE
		|-> decoded.bank_select == $past(fetch_word[8])
		&& decoded.file_addr == $past(fetch_word[7:0]))
		else $error("bad access");
	AST_BIT: assert property (
		decoded.valid && decoded.op_class == IFD_CLS_BIT
		|-> decoded.bit_mask == (8'h01 << decoded.bit_num))
		else $error("bad mask");
	AST_SECOND: assert property (
		decoded.valid && decoded.two_word
		|-> decoded.second_word[15:12] == IFD_SECOND_MARK)
		else $error("bad mark");
	AST_TAKEN: assert property (
		took_single ##0 $past(cond_taken && table_info.conditional)
		|-> ##4 cycle_strobe && !fetch_next) else $error("no extra cycle");
	AST_TMODE: assert property (
		fetch_next && $past(table_info.uses_tmode)
		|-> decoded.tbl_mode == $past(fetch_word[1:0]))
		else $error("bad table mode");
endmodule : ifd_monitor

/* ifd_decoder_tb.sv */
// Self-checking bench for the instruction decoder.
// Assumes the table model answers the decoder's table index.
`timescale 1ns/100ps
module ifd_decoder_tb
	import ifd_pkg::*;
;
	logic                  clk_sys = 1'b0;
	logic                  sys_rst = 1'b1;
	logic [IFD_WORD_W-1:0] fetch_word = 16'h0000;
	logic                  fetch_valid = 1'b0;
	logic                  cond_taken = 1'b0;
	ifd_table_t            table_info;
	logic [IFD_OPC_W-1:0]  table_opcode;
	ifd_decoded_t          decoded;
	logic                  cycle_strobe;
	logic                  fetch_next;
	logic                  busy;
	int                    fail_count = 0;
	int                    checks = 0;
	int                    edges;
	always #2 clk_sys = ~clk_sys;
	ifd_table_model tbl_u (.table_opcode(table_opcode),
		.table_info(table_info));
	ifd_decoder dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.fetch_word(fetch_word), .fetch_valid(fetch_valid),
		.table_info(table_info), .cond_taken(cond_taken),
		.table_opcode(table_opcode), .decoded(decoded),
		.cycle_strobe(cycle_strobe), .fetch_next(fetch_next), .busy(busy));
	task automatic report_and_stop;
		if (fail_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic run(input logic [15:0] w, input logic c);
		@(negedge clk_sys);
		fetch_word = w;
		fetch_valid = 1'b1;
		cond_taken = c;
		edges = 0;
		do
		begin
			@(posedge clk_sys);
			#1;
			edges++;
		end while (fetch_next !== 1'b1 && edges < 16);
		if (edges >= 16)
		begin
			fail_count++;
			report_and_stop();
		end
	endtask : run
	task automatic sc_byte;
		for (int d = 0; d < 2; d++)
		begin
			run(d ? 16'h035A : 16'h015A, 1'b0);
			cmp(16'(edges), 16'h0004);
			cmp(16'(decoded.op_class), 16'(IFD_CLS_BYTE));
			cmp(16'(decoded.to_file), 16'(d));
			cmp(16'(decoded.to_working), 16'(d == 0));
			cmp(16'(decoded.bank_select), 16'h0001);
			cmp(16'(decoded.file_addr), 16'h005A);
		end
	endtask : sc_byte
	task automatic sc_bit;
		for (int b = 0; b < 8; b++)
		begin
			run(16'h4033 | 16'(b << 9), 1'b0);
			cmp(16'(decoded.bit_mask), 16'h0001 << b);
		end
	endtask : sc_bit
	task automatic sc_literal;
		run(16'h80A5, 1'b0);
		cmp(16'(decoded.literal), 16'h00A5);
		run(16'h9020, 1'b0);
		cmp(16'(decoded.ptr_sel), 16'h0002);
		cmp(16'(decoded.write_pointer), 16'h0001);
	endtask : sc_literal
	task automatic sc_control;
		for (int m = 0; m < 4; m++)
		begin
			run(16'hB000 | 16'(m), 1'b0);
			cmp(16'(decoded.tbl_mode), 16'(m));
		end
		run(16'hA001, 1'b0);
		cmp(16'(decoded.fast_save), 16'h0001);
		cmp(16'(busy), 16'h0001);
		run(16'h0000, 1'b0);
		cmp(16'(edges), 16'h0008);
		cmp(16'(busy), 16'h0000);
	endtask : sc_control
	task automatic sc_skip;
		for (int c = 1; c >= 0; c--)
		begin
			run(16'hD000, c[0]);
			run(16'h0000, 1'b0);
			cmp(16'(edges), c ? 16'h0008 : 16'h0004);
		end
	endtask : sc_skip
	task automatic sc_double;
		for (int c = 0; c < 2; c++)
		begin
			run(c ? 16'hE012 : 16'hC012, c[0]);
			cmp(16'(busy), 16'h0001);
			run(16'hF345, c[0]);
			cmp(decoded.second_word, 16'hF345);
			cmp(16'(busy), 16'(c));
			run(16'h0000, 1'b0);
			cmp(16'(edges), c ? 16'h0008 : 16'h0004);
		end
		run(16'hF0AA, 1'b0);
		cmp(16'(decoded.is_nop), 16'h0001);
	endtask : sc_double
	task automatic sc_idle;
		@(negedge clk_sys);
		fetch_valid = 1'b0;
		edges = 0;
		do
		begin
			@(posedge clk_sys);
			#1;
			edges++;
		end while (cycle_strobe !== 1'b1 && edges < 16);
		if (edges >= 16)
		begin
			fail_count++;
			report_and_stop();
		end
		cmp(16'(edges), 16'h0004);
		cmp(16'(fetch_next), 16'h0000);
		cmp(16'(decoded.valid), 16'h0000);
	endtask : sc_idle
	task automatic sc_reset;
		run(16'hA001, 1'b0);
		cmp(16'(busy), 16'h0001);
		@(negedge clk_sys);
		sys_rst = 1'b1;
		@(negedge clk_sys);
		cmp(16'(busy), 16'h0000);
		cmp(16'(cycle_strobe), 16'h0000);
		cmp(16'(decoded.valid), 16'h0000);
		sys_rst = 1'b0;
		run(16'h0000, 1'b0);
		cmp(16'(edges), 16'h0003);
	endtask : sc_reset
	initial
	begin
		repeat (5) @(negedge clk_sys);
		sys_rst = 1'b0;
		run(16'h0000, 1'b0);
		sc_byte();
		sc_bit();
		sc_literal();
		sc_control();
		sc_skip();
		sc_double();
		sc_idle();
		sc_reset();
		report_and_stop();
	end
endmodule : ifd_decoder_tb
bind ifd_decoder ifd_monitor mon_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.fetch_word(fetch_word), .fetch_valid(fetch_valid),
	.table_info(table_info), .cond_taken(cond_taken), .decoded(decoded),
	.cycle_strobe(cycle_strobe), .fetch_next(fetch_next));
